// ==== logic/ascd_host.v ====
`timescale 1ns/100ps
`include "ascd_regs.vh"
// host-side sequencer: issues six back-to-back reads and a hardware store
// a command is taken only in idle and while the device is not storing;
// from then on the six reads run with no pause for anything else, so an
// interrupt routine sharing the bus must wait for cmd_done_out
// each read holds its address and strobes for a fixed number of cycles
// sized to cover the slowest access time, which costs a little speed on
// fast parts but needs no wait input from the memory
// the automatic-store setting only survives power loss after a store;
// software follows an enable or disable command with a store command
// a hardware store request is a short low pulse on the open-drain pin;
// the device then holds the pin low itself for as long as it stores
module ascd_host (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        cmd_valid_in,        // request a command
    input  wire [1:0]  cmd_code_in,         // dis/en/store/recall
    input  wire        use_oe_in,           // time reads with output enable
    input  wire        hw_store_in,         // pulse: request hardware store
    input  wire        store_req_busy_n_in, // store pin level from wire
    output wire        cmd_ready_out,       // sequencer idle and busy_out low
    output reg         cmd_done_out,        // pulse when sixth read ends
    output reg         busy_out,            // store pin seen low: device store or own request
    output reg  [14:0] addr_out,            // address bus
    output reg         ce_n_out,            // chip enable strobe
    output reg         oe_n_out,            // output enable strobe
    output reg         we_n_out,            // write enable, always high
    output reg         store_req_busy_n_out,// drives low for request
    output reg         store_req_busy_n_oe_out // high while driving
);
    // sequencer states: idle, read strobe, gap between reads, store pulse
    localparam ST_IDLE = 2'h0;
    localparam ST_STRB = 2'h1;
    localparam ST_GAP  = 2'h2;
    localparam ST_HSB  = 2'h3;
    localparam [2:0] LAST_STEP = 3'h5;
    // strobe length in cycles, rounded up from the access time
    localparam integer STRB_CYC = `ASCD_STROBE_CYC;
    localparam [3:0] STRB_CNT  = STRB_CYC[3:0];

    reg [1:0]  state_ff;   // sequencer state
    reg [2:0]  step_ff;    // read index 0..5
    reg [3:0]  cnt_ff;     // strobe / gap timer
    reg [1:0]  cmd_ff;     // latched command
    reg        oe_mode_ff; // latched strobe choice
    reg [2:0]  sync_ff;    // store pin synchroniser
    reg [1:0]  nxt_state;
    reg [2:0]  nxt_step;
    reg [3:0]  nxt_cnt;
    wire       take_cmd;   // command accepted on this edge
    wire [1:0] cur_cmd;    // command behind the address being loaded
    wire       cur_oe;     // strobe choice for the read being loaded

    // in idle the request itself is used, later its latched copy
    assign take_cmd = (state_ff == ST_IDLE) && cmd_valid_in && cmd_ready_out;
    assign cur_cmd  = (state_ff == ST_IDLE) ? cmd_code_in : cmd_ff;
    assign cur_oe   = (state_ff == ST_IDLE) ? use_oe_in : oe_mode_ff;

    // address of each step; prefix then chosen command
    function [14:0] step_addr;
        input [2:0] s;
        input [1:0] c;
        begin
            case (s)
                3'h0: step_addr = `ASCD_SEQ_A0;
                3'h1: step_addr = `ASCD_SEQ_A1;
                3'h2: step_addr = `ASCD_SEQ_A2;
                3'h3: step_addr = `ASCD_SEQ_A3;
                3'h4: step_addr = `ASCD_SEQ_A4;
                default: begin
                    case (c)
                        `ASCD_CMD_DIS_C:   step_addr = `ASCD_CMD_DIS;
                        `ASCD_CMD_EN_C:    step_addr = `ASCD_CMD_EN;
                        // store also makes a changed enable setting stick
                        `ASCD_CMD_STORE_C: step_addr = `ASCD_CMD_STORE;
                        default:           step_addr = `ASCD_CMD_RECALL;
                    endcase
                end
            endcase
        end
    endfunction

    // idle only; a store from the device also holds off commands
    assign cmd_ready_out = (state_ff == ST_IDLE) && !busy_out;

    // next-state logic
    always @* begin
        nxt_state = state_ff;
        nxt_step  = step_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cmd_valid_in && cmd_ready_out) begin
                    nxt_state = ST_STRB;
                    nxt_step  = 3'h0;
                    nxt_cnt   = STRB_CNT;
                // a command wins over a store request in the same cycle
                end else if (hw_store_in && !busy_out) begin
                    nxt_state = ST_HSB;
                    nxt_cnt   = STRB_CNT;
                end
            end
            ST_STRB: begin
                // count the strobe down, then gap or finish after the sixth
                if (cnt_ff > 4'h1) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else if (step_ff == LAST_STEP) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_state = ST_GAP;
                    nxt_cnt   = 4'h1;
                end
            end
            ST_GAP: begin
                // no other access slips in; next read follows at once
                nxt_state = ST_STRB;
                nxt_step  = step_ff + 3'h1;
                nxt_cnt   = STRB_CNT;
            end
            ST_HSB: begin
                // request pulse as long as a read strobe
                if (cnt_ff > 4'h1) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // state registers; a reset in mid-sequence abandons the command
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            step_ff  <= 3'h0;
            cnt_ff   <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            step_ff  <= nxt_step;
            cnt_ff   <= nxt_cnt;
        end
    end

    // store pin synchroniser: the pin comes from outside the clock domain,
    // so three flops; busy changes only once stages two and three agree,
    // which keeps a single sampled glitch from showing
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_ff  <= 3'h7; // idle pin is pulled high
            busy_out <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], store_req_busy_n_in};
            if (sync_ff[1] == sync_ff[2]) begin
                busy_out <= !sync_ff[2];
            end
        end
    end

    // command latch: code and strobe choice held for the whole sequence
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_ff     <= 2'h0;
            oe_mode_ff <= 1'b0;
        end else if (take_cmd) begin
            cmd_ff     <= cmd_code_in;
            oe_mode_ff <= use_oe_in;
        end
    end

    // completion pulse, one cycle, on the edge that ends the sixth read
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_done_out <= 1'b0;
        end else begin
            cmd_done_out <= (state_ff == ST_STRB) && (nxt_state == ST_IDLE);
        end
    end

    // bus pins, registered so address and strobes never glitch;
    // the address is loaded on the same edge at which its strobe falls
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_out <= 15'h0000;
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
        end else begin
            we_n_out <= 1'b1; // reads only; a write would break the sequence
            if (nxt_state == ST_STRB) begin
                addr_out <= step_addr(nxt_step, cur_cmd);
                ce_n_out <= 1'b0; // both strobes low: a read in either mode
                oe_n_out <= 1'b0;
            end else if (nxt_state == ST_GAP) begin
                // oe mode ends each read but the sixth with oe only, ce stays low
                ce_n_out <= cur_oe ? 1'b0 : 1'b1;
                oe_n_out <= 1'b1;
            end else begin
                // idle or store request: bus released
                ce_n_out <= 1'b1;
                oe_n_out <= 1'b1;
            end
        end
    end

    // open-drain store request: the level is low from the first edge after reset and only the
    // enable moves, so the pin is never driven high against the device
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            store_req_busy_n_out    <= 1'b1;
            store_req_busy_n_oe_out <= 1'b0;
        end else begin
            store_req_busy_n_out    <= 1'b0;
            store_req_busy_n_oe_out <= (nxt_state == ST_HSB);
        end
    end
endmodule // ascd_host

// ==== logic/ascd_regs.vh ====
// Summary of operation
// - five fixed prefix reads precede every command
// - reads timed by chip or output enable
// - manual store needed to keep setting
// - six reads back to back, uninterrupted
// - store pin low requests or shows busy
`ifndef ASCD_REGS_VH
`define ASCD_REGS_VH
`define ASCD_ADDR_W      15
`define ASCD_SEQ_A0      15'h0E38
`define ASCD_SEQ_A1      15'h31C7
`define ASCD_SEQ_A2      15'h03E0
`define ASCD_SEQ_A3      15'h3C1F
`define ASCD_SEQ_A4      15'h303F
`define ASCD_CMD_DIS     15'h03F8
`define ASCD_CMD_EN      15'h07F0
`define ASCD_CMD_STORE   15'h0FC0
`define ASCD_CMD_RECALL  15'h0C63
`define ASCD_CMD_DIS_C   2'h0
`define ASCD_CMD_EN_C    2'h1
`define ASCD_CMD_STORE_C 2'h2
`define ASCD_CMD_RECALL_C 2'h3
`define ASCD_CYC_NS      25
`define ASCD_ACC_NS      45
`define ASCD_STROBE_CYC  ((`ASCD_ACC_NS + `ASCD_CYC_NS - 1) / `ASCD_CYC_NS)
`define ASCD_GAP_CYC     1
`endif

// ==== tb/ascd_host_properties.sv ====
`timescale 1ns/100ps
// pin checks on the host sequencer
module ascd_host_properties(input wire clk_in, rst_n_in, store_req_busy_n_in, cmd_done_out,
    input wire cmd_ready_out, busy_out, ce_n_out, oe_n_out, we_n_out, store_req_busy_n_out,
    input wire store_req_busy_n_oe_out, input wire [14:0] addr_out);
    wire rd = !ce_n_out && !oe_n_out; // read step live
    wire drv = store_req_busy_n_oe_out; // host drives pin
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_no_write: assert property (we_n_out) else $error("write");
    a_addr_hold: assert property (rd && $past(rd) |-> $stable(addr_out))
        else $error("addr");
    a_step_len: assert property ($rose(rd) |=> rd ##1 !rd) else $error("step");
    a_done_end: assert property (cmd_done_out |-> !rd && ($past(rd) || $past(rd, 2)))
        else $error("done");
    a_idle_quiet: assert property (cmd_ready_out |-> !rd) else $error("idle");
    a_pin_low: assert property (drv |-> !store_req_busy_n_out) else $error("pin");
    a_pin_two: assert property ($rose(drv) |=> drv ##1 !drv) else $error("len");
    a_busy_seen: assert property (!store_req_busy_n_in [*5] |=> busy_out)
        else $error("busy");
    c_done: cover property (cmd_done_out);
    c_busy: cover property ($rose(busy_out));
    c_drive: cover property ($rose(drv));
endmodule // ascd_host_properties
bind ascd_host ascd_host_properties u_props(.*);

// ==== tb/ascd_mem_model.sv ====
`timescale 1ns/100ps
// memory side: follows command reads, pulls pin low while storing
module ascd_mem_model(input wire clk_in, ce_n_out, oe_n_out, we_n_out, sram_write_in,
    input wire supply_low_in, store_req_busy_n_out, store_req_busy_n_oe_out,
    input wire [14:0] addr_out, output wire store_req_busy_n_in, output reg auto_en_ff);
    localparam [74:0] PRE = {15'h0E38, 15'h31C7, 15'h03E0, 15'h3C1F, 15'h303F};
    reg [2:0] idx_ff; // prefix reads matched
    reg [3:0] st_ff; // store cycles left
    reg dirty_ff, was_ff; // written since store; read last cycle
    wire rd = !ce_n_out && !oe_n_out && we_n_out; // both strobes low, in either timing mode
    wire cmd = was_ff && !rd && idx_ff == 3'h5; // sixth read ends
    wire drv_h = store_req_busy_n_oe_out && !store_req_busy_n_out; // host pulls low
    // power-up state of the part; the host's reset does not reach it
    initial begin
        auto_en_ff = 1'b1; // shipped enabled
        idx_ff = 3'h0;
        st_ff = 4'h0;
        dirty_ff = 1'b1;
        was_ff = 1'b0;
    end
    // pulled up: low while either side drives it
    assign store_req_busy_n_in = !(drv_h || |st_ff);
    always @(posedge clk_in) begin
        was_ff <= rd;
        if (|st_ff) st_ff <= st_ff - 4'h1;
        else if ((drv_h || (supply_low_in && auto_en_ff)) && dirty_ff) begin
            st_ff <= 4'h8;
            dirty_ff <= 1'b0;
        end
        // mismatch restarts, current read may begin a new prefix
        if (was_ff && !rd) idx_ff <= (!cmd && addr_out == PRE[74 - idx_ff * 15 -: 15]) ?
            idx_ff + 3'h1 : {2'h0, addr_out == 15'h0E38};
        if (cmd && addr_out == 15'h03F8) auto_en_ff <= 1'b0;
        if (cmd && addr_out == 15'h07F0) auto_en_ff <= 1'b1;
        if (cmd && addr_out == 15'h0FC0) begin
            st_ff <= 4'h8;
            dirty_ff <= 1'b0;
        end
        if (cmd && addr_out == 15'h0C63) dirty_ff <= 1'b0; // recall clears pending write
        if (sram_write_in) dirty_ff <= 1'b1; // another master wrote the array
    end
endmodule // ascd_mem_model

// ==== tb/test_auto_save_cmd_detector.sv ====
`timescale 1ns/100ps
module test_auto_save_cmd_detector;
    reg clk_in = 0, rst_n_in = 0, cmd_valid_in = 0, use_oe_in = 0, hw_store_in = 0;
    reg sram_write_in = 0, supply_low_in = 0; // far-side write and supply drop
    reg [1:0] cmd_code_in = 2'h0; // command choice
    wire cmd_ready_out, cmd_done_out, busy_out, ce_n_out, oe_n_out, we_n_out, auto_en_ff;
    wire store_req_busy_n_in, store_req_busy_n_out, store_req_busy_n_oe_out; // store pin
    wire [14:0] addr_out;
    integer err_total = 0, checks = 0, i, n, m;
    always #12.5 clk_in = ~clk_in;
    ascd_host u_dut(.*);
    ascd_mem_model u_mem(.*);
    task chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %b", $time, got);
        end
    endtask
    task final_report;
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task tick; @(posedge clk_in); #2; endtask
    // a real store holds busy well past a bare two-cycle request
    task watch; n = 0; for (i = 0; i < 40; i++) begin tick; n += busy_out === 1'b1; end endtask
    task run_cmd(input logic [1:0] c, input logic o);
        cmd_code_in = c;
        use_oe_in = o;
        for (i = 0; i < 60 && cmd_ready_out !== 1'b1; i++) tick;
        cmd_valid_in = 1;
        tick;
        cmd_valid_in = 0;
        n = 0;
        m = 0;
        for (i = 0; i < 40; i++) begin tick; n += cmd_done_out === 1'b1; m += busy_out === 1'b1; end
        chk(n == 1, 1);
    endtask
    // disable, keep it with a store, then enable with oe-timed reads
    task t_toggle;
        run_cmd(0, 0);
        chk(auto_en_ff, 0);
        run_cmd(2, 0);
        chk(m > 5, 1);
        run_cmd(1, 1);
        chk(auto_en_ff, 1);
    endtask
    // hardware store request; e says whether a real store should follow
    task t_hw(input logic e);
        hw_store_in = 1;
        tick;
        hw_store_in = 0;
        watch;
        chk(n > 5, e);
    endtask
    // a write on the far side, then a one-cycle supply drop
    task drop;
        sram_write_in = 1;
        tick;
        sram_write_in = 0;
        supply_low_in = 1;
        tick;
        supply_low_in = 0;
        watch;
    endtask
    // supply drop stores only while automatic store is enabled
    task t_supply;
        drop;
        chk(n > 5, 1);
        run_cmd(0, 1);
        drop;
        chk(n > 5, 0);
        run_cmd(1, 0);
        chk(auto_en_ff, 1);
    endtask
    // software store, then a recall that drops the pending write
    task t_sw;
        run_cmd(2, 1);
        chk(m > 5, 1);
        sram_write_in = 1;
        tick;
        sram_write_in = 0;
        run_cmd(3, 0);
        t_hw(0);
    endtask
    // host reset in mid-sequence: the device must not act on half a command
    task t_abort;
        cmd_code_in = 2'h0;
        use_oe_in = 0;
        cmd_valid_in = 1;
        tick;
        cmd_valid_in = 0;
        repeat (6) tick;
        rst_n_in = 0;
        tick;
        rst_n_in = 1;
        repeat (4) tick;
        chk(ce_n_out, 1);
        chk(auto_en_ff, 1);
    endtask
    initial begin #100000; err_total++; final_report; end
    initial begin
        repeat (8) @(posedge clk_in);
        #2 rst_n_in = 1;
        repeat (4) tick;
        chk(auto_en_ff, 1);
        t_hw(1);
        t_hw(0);
        t_abort;
        t_toggle;
        t_supply;
        t_sw;
        final_report;
    end
endmodule // test_auto_save_cmd_detector
